// [design/mult_datapath.sv]
`timescale 1ns/1ns
module mult_datapath #(
    parameter int OPD_W = 16,
    parameter int ACC_W = 48
) (
    input wire logic unsigned_sel,
    input wire logic accumulate,
    input wire logic neg_sub,
    input wire logic [OPD_W-1:0] opa,
    input wire logic [OPD_W-1:0] opb,
    input wire logic [ACC_W-1:0] acc,
    output logic [ACC_W-1:0] result,
    output logic overflow
);
    localparam int PRD_W = 2 * OPD_W;
    localparam int EXT_W = ACC_W + 1 - PRD_W;

    logic [PRD_W-1:0] prod_u;
    logic [PRD_W-1:0] prod_s;
    logic [PRD_W-1:0] prod;
    logic [ACC_W:0] prod_x;
    logic [ACC_W:0] acc_x;
    logic [ACC_W:0] sum_x;
    logic [ACC_W:0] neg_x;

    // The adder is purely combinational, so the result follows every input change.
    assign prod_u = PRD_W'({{OPD_W{1'b0}}, opa} * {{OPD_W{1'b0}}, opb});
    assign prod_s = PRD_W'($signed({{OPD_W{opa[OPD_W-1]}}, opa}) *
                           $signed({{OPD_W{opb[OPD_W-1]}}, opb}));
    assign prod = unsigned_sel ? prod_u : prod_s;
    assign prod_x = unsigned_sel ? {{EXT_W{1'b0}}, prod} : {{EXT_W{prod[PRD_W-1]}}, prod};
    assign acc_x = unsigned_sel ? {1'b0, acc} : {acc[ACC_W-1], acc};
    assign sum_x = neg_sub ? acc_x - prod_x : acc_x + prod_x;
    assign neg_x = (ACC_W + 1)'(0) - prod_x;

    assign result = accumulate ? sum_x[ACC_W-1:0] :
                    (neg_sub && !unsigned_sel) ? neg_x[ACC_W-1:0] : prod_x[ACC_W-1:0];
    // An unsigned negate cannot be represented; it is flagged and the plain product kept.
    assign overflow = accumulate ?
                      (unsigned_sel ? sum_x[ACC_W] : sum_x[ACC_W] ^ sum_x[ACC_W-1]) :
                      (neg_sub & unsigned_sel);
endmodule

// [design/mult_pkg.sv]
package mult_pkg;
    localparam int REG_ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int ACC_WORDS = 3;

    localparam logic [REG_ADDR_W-1:0] OFF_CONTROL = 8'h00;
    localparam logic [REG_ADDR_W-1:0] OFF_OPERAND_FIRST = 8'h04;
    localparam logic [REG_ADDR_W-1:0] OFF_OPERAND_SECOND = 8'h08;
    localparam logic [REG_ADDR_W-1:0] OFF_ACC_LOW = 8'h0C;
    localparam logic [REG_ADDR_W-1:0] ACC_WORD_STRIDE = 8'h04;
    localparam logic [REG_ADDR_W-1:0] OFF_VIEW_UPPER = 8'h18;
    localparam logic [REG_ADDR_W-1:0] OFF_VIEW_LOWER = 8'h1C;

    localparam int CTL_UNSIGNED = 0;
    localparam int CTL_ACCUMULATE = 1;
    localparam int CTL_NEG_SUB = 2;
    localparam int CTL_OPCOUNT = 3;
    localparam int CTL_SQUARE = 4;
    localparam int CTL_CLEAR = 5;
    localparam int CTL_INHIBIT = 6;
    localparam int CTL_OVERFLOW = 7;

    localparam logic [7:0] CTL_STORE_MASK = 8'h5F;
    localparam logic [7:0] CTL_RESET = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [design/multiplier_result_readout.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Functional notes
// RQ1: Accumulator low word is read/write register.
// RQ2: Upper view shows result bytes three, two.
// RQ3: Lower view shows result bytes one, zero.
// RQ4: Views come combinationally from the adder.
// RQ5: Views follow control, operand, accumulator changes.
// RQ6: Code 21h clears, unsigned plain multiply.
// RQ7: Code 03h unsigned multiply-accumulate.
// RQ8: Codes 07h, 06h multiply-subtract.
// RQ9: Code 24h clears, signed multiply-negate.
// RQ10: Inhibit bit keeps accumulator unchanged.
// RQ11: Clear bit zeroes data, flag, counter.
// RQ12: Count bit picks one or two operands.
// RQ13: Signedness bit zero means signed operands.
// RQ14: Views ignore writes, read zero until operation.
module multiplier_result_readout
    import mult_pkg::*;
#(
    parameter int OPD_W = 16,
    parameter int ACC_W = 48
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [REG_ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [DATA_W/8-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [REG_ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp
);
    localparam int PRD_W = 2 * OPD_W;

    if (OPD_W > DATA_W / 2 || ACC_W != ACC_WORDS * OPD_W) begin : g_bad_width
        $error("Operands must fit a half word and the accumulator must be three words.");
    end

    function automatic logic is_reg(input logic [REG_ADDR_W-1:0] a,
                                    input logic [REG_ADDR_W-1:0] off);
        return a[REG_ADDR_W-1:2] == off[REG_ADDR_W-1:2];
    endfunction

    function automatic logic [OPD_W-1:0] merge_word(input logic [OPD_W-1:0] old,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [DATA_W/8-1:0] strb);
        logic [OPD_W-1:0] m;
        m = old;
        for (int b = 0; b < OPD_W; b++) begin
            if (strb[b / 8]) begin
                m[b] = data[b];
            end
        end
        return m;
    endfunction

    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [OPD_W-1:0] opa_q;
    logic [OPD_W-1:0] opa_d;
    logic [OPD_W-1:0] opb_q;
    logic [OPD_W-1:0] opb_d;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_d;
    logic [ACC_W-1:0] acc_bus_d;
    logic of_q;
    logic of_d;
    logic done_q;
    logic done_d;
    logic a_ld_q;
    logic a_ld_d;
    logic b_ld_q;
    logic b_ld_d;
    logic start_q;
    logic start_d;
    logic aw_hold_q;
    logic w_hold_q;
    logic [REG_ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W/8-1:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_fire;
    logic wr_ctrl;
    logic wr_a;
    logic wr_b;
    logic wr_mapped;
    logic clear_all;
    logic opd_wr;
    logic acc_wb;
    logic [OPD_W-1:0] opd_in_a;
    logic [OPD_W-1:0] opd_in_b;
    logic [ACC_W-1:0] result;
    logic overflow;
    logic [OPD_W-1:0] view_upper;
    logic [OPD_W-1:0] view_lower;
    logic [ACC_WORDS-1:0] wr_acc_hit;
    logic [ACC_WORDS-1:0] rd_acc_hit;
    logic [OPD_W-1:0] acc_rd_or [ACC_WORDS+1];
    logic rd_take;
    logic rd_mapped;
    logic [DATA_W-1:0] rd_word;
    logic [7:0] ctrl_view;

    mult_datapath #(
        .OPD_W(OPD_W),
        .ACC_W(ACC_W)
    ) u_datapath (
        .unsigned_sel(ctrl_q[CTL_UNSIGNED]), // [RQ13]
        .accumulate(ctrl_q[CTL_ACCUMULATE]), // [RQ7]
        .neg_sub(ctrl_q[CTL_NEG_SUB]), // [RQ8] [RQ9]
        .opa(opa_q),
        .opb(opb_q),
        .acc(acc_q),
        .result(result),
        .overflow(overflow)
    );

    // Write channel: address and data are caught independently, in either order.
    assign awready = ce & ~aw_hold_q & ~bvalid_q;
    assign wready = ce & ~w_hold_q & ~bvalid_q;
    assign wr_fire = ce & aw_hold_q & w_hold_q & ~bvalid_q;
    assign wr_ctrl = wr_fire & is_reg(awaddr_q, OFF_CONTROL) & wstrb_q[0];
    assign wr_a = wr_fire & is_reg(awaddr_q, OFF_OPERAND_FIRST);
    assign wr_b = wr_fire & is_reg(awaddr_q, OFF_OPERAND_SECOND);
    assign wr_mapped = is_reg(awaddr_q, OFF_CONTROL) | is_reg(awaddr_q, OFF_OPERAND_FIRST) |
                       is_reg(awaddr_q, OFF_OPERAND_SECOND) | (|wr_acc_hit) |
                       is_reg(awaddr_q, OFF_VIEW_UPPER) | is_reg(awaddr_q, OFF_VIEW_LOWER);
    // Valid is masked while frozen so that a handshake cannot complete unseen.
    assign bvalid = bvalid_q & ce;
    assign bresp = bresp_q;

    // Control: the clear bit is never stored, so it always reads back as zero.
    assign clear_all = wr_ctrl & wdata_q[CTL_CLEAR]; // [RQ11]
    assign ctrl_d = wr_ctrl ? (wdata_q[7:0] & CTL_STORE_MASK) : ctrl_q;
    assign ctrl_view = ctrl_q | ({7'h00, of_q} << CTL_OVERFLOW);

    // Operands: in square mode one write loads both operand registers.
    assign opd_in_a = merge_word(opa_q, wdata_q, wstrb_q);
    assign opd_in_b = merge_word(opb_q, wdata_q, wstrb_q);
    assign opd_wr = wr_a | wr_b;
    assign opa_d = clear_all ? '0 : wr_a ? opd_in_a :
                   (wr_b & ctrl_q[CTL_SQUARE]) ? opd_in_b : opa_q; // [RQ11]
    assign opb_d = clear_all ? '0 : wr_b ? opd_in_b :
                   (wr_a & ctrl_q[CTL_SQUARE]) ? opd_in_a : opb_q;

    // Start is one cycle after the operand write, so the datapath sees the new operand.
    assign start_d = opd_wr & (ctrl_q[CTL_SQUARE] | ctrl_q[CTL_OPCOUNT] |
                               ((a_ld_q | wr_a) & (b_ld_q | wr_b))); // [RQ12]
    assign a_ld_d = (clear_all | start_d) ? 1'b0 : (a_ld_q | wr_a); // [RQ11] [RQ12]
    assign b_ld_d = (clear_all | start_d) ? 1'b0 : (b_ld_q | wr_b);

    // Accumulator words share one write path each, laid out from the low word up.
    for (genvar i = 0; i < ACC_WORDS; i++) begin : g_acc_word
        assign wr_acc_hit[i] = is_reg(awaddr_q,
                                      REG_ADDR_W'(OFF_ACC_LOW + ACC_WORD_STRIDE * i));
        assign rd_acc_hit[i] = is_reg(araddr, REG_ADDR_W'(OFF_ACC_LOW + ACC_WORD_STRIDE * i));
        assign acc_bus_d[i*OPD_W +: OPD_W] = (wr_fire & wr_acc_hit[i]) ?
            merge_word(acc_q[i*OPD_W +: OPD_W], wdata_q, wstrb_q) :
            acc_q[i*OPD_W +: OPD_W]; // [RQ1]
        assign acc_rd_or[i+1] = acc_rd_or[i] | (rd_acc_hit[i] ? acc_q[i*OPD_W +: OPD_W] : '0);
    end
    assign acc_rd_or[0] = '0;

    assign acc_wb = start_q & ~ctrl_q[CTL_INHIBIT]; // [RQ10]
    assign acc_d = clear_all ? '0 : acc_wb ? result : acc_bus_d; // [RQ6] [RQ9] [RQ11]
    assign of_d = clear_all ? 1'b0 : start_q ? overflow : of_q;
    assign done_d = clear_all ? 1'b0 : (start_q | done_q);

    // Views are live adder outputs; they are not latched copies of the last result.
    assign view_upper = done_q ? result[PRD_W-1:OPD_W] : '0; // [RQ2] [RQ4] [RQ5] [RQ14]
    assign view_lower = done_q ? result[OPD_W-1:0] : '0; // [RQ3] [RQ4] [RQ5] [RQ14]

    // Read channel: one read in flight, data captured on the address handshake.
    assign arready = ce & ~rvalid_q;
    assign rd_take = arvalid & arready;
    assign rd_mapped = is_reg(araddr, OFF_CONTROL) | is_reg(araddr, OFF_OPERAND_FIRST) |
                       is_reg(araddr, OFF_OPERAND_SECOND) | (|rd_acc_hit) |
                       is_reg(araddr, OFF_VIEW_UPPER) | is_reg(araddr, OFF_VIEW_LOWER);
    assign rd_word = is_reg(araddr, OFF_CONTROL) ? DATA_W'(ctrl_view) :
                     is_reg(araddr, OFF_OPERAND_FIRST) ? DATA_W'(opa_q) :
                     is_reg(araddr, OFF_OPERAND_SECOND) ? DATA_W'(opb_q) :
                     is_reg(araddr, OFF_VIEW_UPPER) ? DATA_W'(view_upper) :
                     is_reg(araddr, OFF_VIEW_LOWER) ? DATA_W'(view_lower) :
                     DATA_W'(acc_rd_or[ACC_WORDS]);
    assign rvalid = rvalid_q & ce;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTL_RESET;
            opa_q <= '0;
            opb_q <= '0;
            acc_q <= '0;
            of_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            opa_q <= opa_d;
            opb_q <= opb_d;
            acc_q <= acc_d;
            of_q <= of_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_ld_q <= 1'b0;
            b_ld_q <= 1'b0;
            start_q <= 1'b0;
        end else if (ce) begin
            a_ld_q <= a_ld_d;
            b_ld_q <= b_ld_d;
            start_q <= start_d;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            aw_hold_q <= (aw_hold_q | (awvalid & awready)) & ~wr_fire;
            w_hold_q <= (w_hold_q | (wvalid & wready)) & ~wr_fire;
            if (awvalid && awready) begin
                awaddr_q <= awaddr;
            end
            if (wvalid && wready) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (ce) begin
            bvalid_q <= wr_fire | (bvalid_q & ~bready);
            if (wr_fire) begin
                bresp_q <= wr_mapped ? RESP_OKAY : RESP_DECERR;
            end
            rvalid_q <= rd_take | (rvalid_q & ~rready);
            if (rd_take) begin
                rdata_q <= rd_mapped ? rd_word : '0;
                rresp_q <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // Independent reference products for the checks below.
    logic [PRD_W-1:0] chk_uprod;
    logic signed [PRD_W-1:0] chk_sprod;
    logic [ACC_W-1:0] chk_prod_x;
    logic [ACC_W-1:0] chk_expect;
    logic [OPD_W-1:0] chk_res_upper;
    logic [OPD_W-1:0] chk_res_lower;
    assign chk_uprod = PRD_W'(opa_q) * PRD_W'(opb_q);
    assign chk_sprod = PRD_W'($signed(opa_q) * $signed(opb_q));
    assign chk_prod_x = ctrl_q[CTL_UNSIGNED] ? ACC_W'(chk_uprod) : ACC_W'(chk_sprod);
    // The expected result is rebuilt from the control bits, so an adder fault cannot hide.
    assign chk_expect = !ctrl_q[CTL_ACCUMULATE] ?
        ((ctrl_q[CTL_NEG_SUB] && !ctrl_q[CTL_UNSIGNED]) ? ACC_W'(0) - chk_prod_x : chk_prod_x) :
        (ctrl_q[CTL_NEG_SUB] ? acc_q - chk_prod_x : acc_q + chk_prod_x);
    assign chk_res_upper = chk_expect[PRD_W-1:OPD_W];
    assign chk_res_lower = chk_expect[OPD_W-1:0];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_op_start;
        start_q && ce;
    endsequence
    sequence s_op_wb;
        s_op_start and (!ctrl_q[CTL_INHIBIT]);
    endsequence

    acc_low_write_a: assert property ( // [RQ1]
        wr_fire && wr_acc_hit[0] && (&wstrb_q[1:0]) && !start_q
        |=> acc_q[OPD_W-1:0] == $past(wdata_q[OPD_W-1:0]))
        else $error("Accumulator low word did not take the written value.");
    view_upper_a: assert property ( // [RQ2]
        (s_op_start and ctrl_q[CTL_INHIBIT])
        |=> done_q && view_upper == $past(chk_res_upper))
        else $error("Upper view lost the inhibited result.");
    view_lower_a: assert property ( // [RQ3]
        (s_op_start and !ctrl_q[CTL_ACCUMULATE])
        |=> done_q && view_lower == $past(chk_res_lower))
        else $error("Lower view lost the plain multiply result.");
    plain_unsigned_a: assert property ( // [RQ6]
        (s_op_wb and ctrl_q[CTL_UNSIGNED] && !ctrl_q[CTL_ACCUMULATE] && !ctrl_q[CTL_NEG_SUB])
        |=> acc_q == ACC_W'($past(chk_uprod)))
        else $error("Unsigned multiply stored a wrong product.");
    mac_add_a: assert property ( // [RQ7]
        (s_op_wb and ctrl_q[CTL_ACCUMULATE] && !ctrl_q[CTL_NEG_SUB])
        |=> acc_q == $past(acc_q) + $past(chk_prod_x))
        else $error("Multiply-accumulate stored a wrong sum.");
    mac_sub_a: assert property ( // [RQ8]
        (s_op_wb and ctrl_q[CTL_ACCUMULATE] && ctrl_q[CTL_NEG_SUB])
        |=> acc_q == $past(acc_q) - $past(chk_prod_x))
        else $error("Multiply-subtract stored a wrong difference.");
    negate_signed_a: assert property ( // [RQ9]
        (s_op_wb and !ctrl_q[CTL_UNSIGNED] && !ctrl_q[CTL_ACCUMULATE] && ctrl_q[CTL_NEG_SUB])
        |=> acc_q == ACC_W'(0) - $past(chk_prod_x))
        else $error("Signed multiply-negate stored a wrong value.");
    inhibit_hold_a: assert property ( // [RQ10]
        (s_op_start and ctrl_q[CTL_INHIBIT]) |=> $stable(acc_q))
        else $error("Accumulator changed although write-back was inhibited.");
    clear_all_a: assert property ( // [RQ11]
        clear_all |=> acc_q == '0 && opa_q == '0 && opb_q == '0 && !of_q && !a_ld_q
            && !b_ld_q && !done_q && !ctrl_q[CTL_CLEAR])
        else $error("Clear left data, flag or counter set.");
    two_operands_a: assert property ( // [RQ12]
        wr_a && !ctrl_q[CTL_OPCOUNT] && !ctrl_q[CTL_SQUARE] && !b_ld_q |=> !start_q)
        else $error("Operation started before both operands were written.");
    one_operand_a: assert property ( // [RQ12]
        (wr_a || wr_b) && ctrl_q[CTL_OPCOUNT] |=> start_q ##1 (done_q || !ce))
        else $error("Single operand write did not start the operation.");
    signed_plain_a: assert property ( // [RQ13]
        (s_op_wb and !ctrl_q[CTL_UNSIGNED] && !ctrl_q[CTL_ACCUMULATE] && !ctrl_q[CTL_NEG_SUB])
        |=> acc_q == ACC_W'($past(chk_sprod)))
        else $error("Signed multiply stored a wrong product.");
    view_readonly_a: assert property ( // [RQ14]
        wr_fire && (is_reg(awaddr_q, OFF_VIEW_UPPER) || is_reg(awaddr_q, OFF_VIEW_LOWER))
        |=> $stable(acc_q) && $stable(opa_q) && $stable(ctrl_q) && bresp_q == RESP_OKAY)
        else $error("A write to a result view changed state.");
endmodule

// [verif/tb_multiplier_result_readout.sv]
`timescale 1ns/1ns
module tb_multiplier_result_readout;
    import mult_pkg::*;
    localparam logic [7:0] A_MID = OFF_ACC_LOW + ACC_WORD_STRIDE;
    localparam logic [7:0] A_TOP = A_MID + ACC_WORD_STRIDE;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int n_errors = 0;
    int compares = 0;

    // Clock enable is tied high; freezing is outside what this bench exercises.
    multiplier_result_readout uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out(input string what);
        n_errors++;
        $display("[ERR] %0t timeout on %s", $time, what);
        wrap_up();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Ready is looked at on the falling edge, so the verdict never races the rising edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw_p;
        logic w_p;
        logic aw_t;
        logic w_t;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        n = 0;
        while ((aw_p || w_p) && n < 20) begin
            @(negedge sys_clk);
            aw_t = aw_p && awready;
            w_t = w_p && wready;
            @(posedge sys_clk);
            if (aw_t) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_t) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
            n++;
        end
        if (aw_p || w_p) timed_out("write request");
        n = 0;
        @(negedge sys_clk);
        while (bvalid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (bvalid !== 1'b1) timed_out("write response");
        r = bresp;
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic t;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 1'b0;
        n = 0;
        while (!t && n < 20) begin
            @(negedge sys_clk);
            t = arready;
            @(posedge sys_clk);
            if (t) arvalid <= 1'b0;
            n++;
        end
        if (!t) timed_out("read request");
        n = 0;
        @(negedge sys_clk);
        while (rvalid !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (rvalid !== 1'b1) timed_out("read response");
        d = rdata;
        r = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        axi_wr(a, {16'h0000, d}, r);
        chk(32'(r), 32'(RESP_OKAY), "bresp");
    endtask

    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string what);
        logic [1:0] r;
        logic [31:0] d;
        axi_rd(a, d, r);
        chk(d, {16'h0000, e}, what);
        chk(32'(r), 32'(RESP_OKAY), "rresp");
    endtask

    task automatic set_acc(input logic [47:0] v);
        wr(OFF_ACC_LOW, v[15:0]);
        wr(A_MID, v[31:16]);
        wr(A_TOP, v[47:32]);
    endtask

    task automatic acc_chk(input logic [47:0] e);
        rc(OFF_ACC_LOW, e[15:0], "acc low");
        rc(A_MID, e[31:16], "acc mid");
        rc(A_TOP, e[47:32], "acc top");
    endtask

    task automatic view_chk(input logic [31:0] e);
        rc(OFF_VIEW_UPPER, e[31:16], "view upper");
        rc(OFF_VIEW_LOWER, e[15:0], "view lower");
    endtask

    task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b);
        wr(OFF_CONTROL, {8'h00, c});
        wr(OFF_OPERAND_FIRST, a);
        wr(OFF_OPERAND_SECOND, b);
    endtask

    task automatic t_reset();
        acc_chk(48'h0000_0000_0000);
        view_chk(32'h0000_0000);
        $display("reset values done");
    endtask

    task automatic t_plain();
        op(8'h21, 16'h0FFF, 16'h1001);
        acc_chk(48'h0000_00FF_FFFF);
        view_chk(32'h00FF_FFFF);
        wr(OFF_VIEW_UPPER, 16'h1234);
        wr(OFF_VIEW_LOWER, 16'h5678);
        view_chk(32'h00FF_FFFF);
        $display("plain multiply done");
    endtask

    task automatic t_mac();
        wr(OFF_CONTROL, 16'h0020);
        set_acc(48'h0000_0100_0001);
        acc_chk(48'h0000_0100_0001);
        op(8'h03, 16'h0FFF, 16'h1001);
        acc_chk(48'h0000_0200_0000);
        view_chk(32'h02FF_FFFF);
        wr(A_MID, 16'h0100);
        view_chk(32'h01FF_FFFF);
        $display("accumulate done");
    endtask

    task automatic t_sub();
        set_acc(48'h0000_0100_0001);
        op(8'h07, 16'h0FFF, 16'h1001);
        acc_chk(48'h0000_0000_0002);
        set_acc(48'h0000_0100_0001);
        op(8'h06, 16'hF001, 16'h1001);
        acc_chk(48'h0000_0200_0000);
        $display("subtract done");
    endtask

    task automatic t_neg_sign();
        op(8'h24, 16'hF001, 16'h1001);
        acc_chk(48'h0000_00FF_FFFF);
        view_chk(32'h00FF_FFFF);
        op(8'h20, 16'hF001, 16'h1001);
        acc_chk(48'hFFFF_FF00_0001);
        op(8'h21, 16'hF001, 16'h1001);
        acc_chk(48'h0000_0F01_0001);
        $display("negate and sign done");
    endtask

    task automatic t_inhibit();
        op(8'h61, 16'h0FFF, 16'h1001);
        acc_chk(48'h0000_0000_0000);
        view_chk(32'h00FF_FFFF);
        $display("inhibit done");
    endtask

    task automatic t_count();
        wr(OFF_CONTROL, 16'h0021);
        wr(OFF_OPERAND_FIRST, 16'h0005);
        acc_chk(48'h0000_0000_0000);
        view_chk(32'h0000_0000);
        wr(OFF_OPERAND_SECOND, 16'h0003);
        acc_chk(48'h0000_0000_000F);
        // Accumulating makes each single-operand start visible in the sum, except the first, which multiplies by the cleared second operand.
        wr(OFF_CONTROL, 16'h002B);
        wr(OFF_OPERAND_FIRST, 16'h0007);
        wr(OFF_OPERAND_SECOND, 16'h0003);
        wr(OFF_OPERAND_FIRST, 16'h0002);
        acc_chk(48'h0000_0000_001B);
        $display("operand count done");
    endtask

    task automatic t_clear();
        // An unsigned negate raises the overflow flag, so the clear has something to drop.
        wr(OFF_CONTROL, 16'h000D);
        wr(OFF_OPERAND_FIRST, 16'h0005);
        rc(OFF_CONTROL, 16'h008D, "overflow set");
        wr(OFF_CONTROL, 16'h0001);
        wr(OFF_OPERAND_FIRST, 16'h0005);
        wr(OFF_CONTROL, 16'h0020);
        acc_chk(48'h0000_0000_0000);
        rc(OFF_OPERAND_FIRST, 16'h0000, "operand first");
        rc(OFF_OPERAND_SECOND, 16'h0000, "operand second");
        rc(OFF_CONTROL, 16'h0000, "control");
        wr(OFF_OPERAND_SECOND, 16'h0003);
        acc_chk(48'h0000_0000_0000);
        view_chk(32'h0000_0000);
        $display("clear done");
    endtask

    task automatic t_unmapped();
        logic [1:0] r;
        logic [31:0] d;
        axi_rd(8'h40, d, r);
        chk(32'(r), 32'(RESP_DECERR), "unmapped rresp");
        chk(d, 32'h0000_0000, "unmapped rdata");
        axi_wr(8'h40, 32'h0000_FFFF, r);
        chk(32'(r), 32'(RESP_DECERR), "unmapped bresp");
        $display("unmapped done");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_plain();
        t_mac();
        t_sub();
        t_neg_sign();
        t_inhibit();
        t_count();
        t_clear();
        t_unmapped();
        wrap_up();
    end
endmodule
